// file: src/ccr_pkg.sv
// Purpose: constants for the converter configuration register group
// Assumes: byte-wide register port, byte addresses as printed
// Notes:   16-bit codes occupy two consecutive byte addresses, low byte first
package ccr_pkg;

  // ==========================================================
  // address map
  localparam logic [11:0] CCR_ADDR_FS_A_LO   = 12'h030;
  localparam logic [11:0] CCR_ADDR_FS_A_HI   = 12'h031;
  localparam logic [11:0] CCR_ADDR_FS_B_LO   = 12'h032;
  localparam logic [11:0] CCR_ADDR_FS_B_HI   = 12'h033;
  localparam logic [11:0] CCR_ADDR_REF_BYP   = 12'h038;
  localparam logic [11:0] CCR_ADDR_TSTAMP    = 12'h03B;
  localparam logic [11:0] CCR_ADDR_SWING     = 12'h048;
  localparam logic [11:0] CCR_ADDR_IN_SEL    = 12'h060;
  localparam logic [11:0] CCR_ADDR_CAL_EN    = 12'h061;

  // ==========================================================
  // reset values
  localparam logic [15:0] CCR_RST_FULLSCALE  = 16'hA000;
  localparam logic [7:0]  CCR_RST_REF_BYP    = 8'h00;
  localparam logic [7:0]  CCR_RST_TSTAMP     = 8'h00;
  localparam logic [7:0]  CCR_RST_SWING      = 8'h00;
  localparam logic [7:0]  CCR_RST_IN_SEL     = 8'h01;
  localparam logic [7:0]  CCR_RST_CAL_EN     = 8'h01;

  // ==========================================================
  // field positions
  localparam int CCR_BIT_REF_BYP     = 0;
  localparam int CCR_BIT_TS_RECV     = 0;
  localparam int CCR_BIT_TS_DC       = 1;
  localparam int CCR_LSB_SWING       = 0;
  localparam int CCR_BIT_DUAL_SWAP   = 4;
  localparam int CCR_LSB_SINGLE_IN   = 0;
  localparam int CCR_BIT_CAL_EN      = 0;

  // ==========================================================
  // field encodings
  localparam logic [1:0] CCR_SWING_HIGH     = 2'h0;
  localparam logic [1:0] CCR_SWING_LOW      = 2'h1;
  localparam logic [1:0] CCR_SWING_RSVD     = 2'h2;
  localparam logic [1:0] CCR_SWING_HIGH_Z   = 2'h3;
  localparam logic [1:0] CCR_SINGLE_FIRST   = 2'h1;
  localparam logic [1:0] CCR_SINGLE_SECOND  = 2'h2;

  typedef enum logic [3:0] {
    CCR_DRV_HIGH_SWING   = 4'h1,
    CCR_DRV_LOW_SWING    = 4'h2,
    CCR_DRV_HIGH_Z_SWING = 4'h4,
    CCR_DRV_RESERVED     = 4'h8
  } ccr_drv_mode_t;

endpackage : ccr_pkg

// file: src/ccr_regs.sv
// Purpose: configuration register group of a dual-channel data converter
// Assumes: byte-wide write/read port from the serial configuration decoder
// Notes:   read data registered, one cycle after rd_en
//          host-side ordering of calibration enable is not policed here
//          16-bit codes are written one byte at a time, low byte first
//
// Function
// - first input full-scale code, 16 bits, resets to 0xA000
// - second input full-scale code, 16 bits, same encoding and reset
// - reference bypass bit selects analog core supply as reference
// - timestamp register bit 0 enables timestamp receiver, off at reset
// - timestamp register bit 1 selects DC-coupled termination mode
// - two-bit swing field picks high, low, reserved or high-impedance swing
// - bit 4 swaps inputs between channels in dual-channel mode
// - single-input field picks first (1) or second (2) input when interleaved
// - calibration enable bit runs calibration high, holds it in reset low
// - clearing calibration enable resets encoder and output clock dividers
`timescale 1ns/1ps
module ccr_regs
#(
  parameter int ADDR_W = 12
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [7:0]          wdata,
  output logic      [7:0]          rdata,
  input  wire logic                interleave_mode,
  output logic      [15:0]         input_a_fullscale_code,
  output logic      [15:0]         input_b_fullscale_code,
  output logic                     reference_bypass_bit,
  output logic                     timestamp_receiver_on,
  output logic                     timestamp_dc_coupled_mode,
  output ccr_pkg::ccr_drv_mode_t   output_drive_mode,
  output logic                     channel_a_takes_second,
  output logic                     channel_b_takes_first,
  output logic                     interleave_first_input_mode,
  output logic                     interleave_second_input_mode,
  output logic                     calibration_run,
  output logic                     calibration_reset,
  output logic                     divider_reset
);

  import ccr_pkg::*;

  // ==========================================================
  // storage
  logic [15:0] input_a_fullscale;
  logic [15:0] input_b_fullscale;
  logic [7:0]  reference_bypass;
  logic [7:0]  timestamp_input_control;
  logic [7:0]  output_swing_mode;
  logic [7:0]  input_select;
  logic [7:0]  calibration_enable;

  // address decode on the low twelve bits; a wider port aliases the map
  // every twelve-bit span, which the host must keep in mind
  wire logic [11:0] a12 = 12'(addr);
  wire logic hit_fs_a_lo = (a12 == CCR_ADDR_FS_A_LO);
  wire logic hit_fs_a_hi = (a12 == CCR_ADDR_FS_A_HI);
  wire logic hit_fs_b_lo = (a12 == CCR_ADDR_FS_B_LO);
  wire logic hit_fs_b_hi = (a12 == CCR_ADDR_FS_B_HI);
  wire logic hit_ref     = (a12 == CCR_ADDR_REF_BYP);
  wire logic hit_ts      = (a12 == CCR_ADDR_TSTAMP);
  wire logic hit_swing   = (a12 == CCR_ADDR_SWING);
  wire logic hit_in_sel  = (a12 == CCR_ADDR_IN_SEL);
  wire logic hit_cal     = (a12 == CCR_ADDR_CAL_EN);

  // ==========================================================
  // write strobes, one per byte address; a write to an unmapped
  // address raises none of them and is dropped
  wire logic wr_fs_a_lo = wr_en && hit_fs_a_lo;
  wire logic wr_fs_a_hi = wr_en && hit_fs_a_hi;
  wire logic wr_fs_b_lo = wr_en && hit_fs_b_lo;
  wire logic wr_fs_b_hi = wr_en && hit_fs_b_hi;
  wire logic wr_ref     = wr_en && hit_ref;
  wire logic wr_ts      = wr_en && hit_ts;
  wire logic wr_swing   = wr_en && hit_swing;
  wire logic wr_in_sel  = wr_en && hit_in_sel;
  wire logic wr_cal     = wr_en && hit_cal;

  // byte strobes gathered per channel, index 0 is the first input
  wire logic [1:0] wr_fs_lo = {wr_fs_b_lo, wr_fs_a_lo};
  wire logic [1:0] wr_fs_hi = {wr_fs_b_hi, wr_fs_a_hi};

  // ==========================================================
  // full-scale codes; each byte lands alone, so a 16-bit change
  // shows a mixed code between its two byte writes
  for (genvar ch = 0; ch < 2; ch++) begin : g_fullscale
    logic [15:0] fullscale;
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        fullscale <= CCR_RST_FULLSCALE;
      end else begin
        if (wr_fs_lo[ch]) fullscale[7:0]  <= wdata;
        if (wr_fs_hi[ch]) fullscale[15:8] <= wdata;
      end
    end
  end : g_fullscale

  // per-channel codes under their register names
  assign input_a_fullscale = g_fullscale[0].fullscale;
  assign input_b_fullscale = g_fullscale[1].fullscale;

  // ==========================================================
  // byte registers; whole bytes stored, reserved bits included

  // reference bypass, only bit 0 acts
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reference_bypass <= CCR_RST_REF_BYP;
    end else if (wr_ref) begin
      reference_bypass <= wdata;
    end
  end

  // timestamp receiver control, receiver off after reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timestamp_input_control <= CCR_RST_TSTAMP;
    end else if (wr_ts) begin
      timestamp_input_control <= wdata;
    end
  end

  // output swing mode, high swing after reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      output_swing_mode <= CCR_RST_SWING;
    end else if (wr_swing) begin
      output_swing_mode <= wdata;
    end
  end

  // input select, first input after reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      input_select <= CCR_RST_IN_SEL;
    end else if (wr_in_sel) begin
      input_select <= wdata;
    end
  end

  // calibration enable, running after reset; clearing it stops
  // calibration and the dividers from the very next edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      calibration_enable <= CCR_RST_CAL_EN;
    end else if (wr_cal) begin
      calibration_enable <= wdata;
    end
  end

  // ==========================================================
  // read mux; address hits are exclusive, so an and-or tree is enough,
  // and unmapped addresses fall through to zero
  wire logic [7:0] next_rdata =
      ({8{hit_fs_a_lo}} & input_a_fullscale[7:0])
    | ({8{hit_fs_a_hi}} & input_a_fullscale[15:8])
    | ({8{hit_fs_b_lo}} & input_b_fullscale[7:0])
    | ({8{hit_fs_b_hi}} & input_b_fullscale[15:8])
    | ({8{hit_ref}}     & reference_bypass)
    | ({8{hit_ts}}      & timestamp_input_control)
    | ({8{hit_swing}}   & output_swing_mode)
    | ({8{hit_in_sel}}  & input_select)
    | ({8{hit_cal}}     & calibration_enable);

  // read data register; it holds the last value between reads, so a
  // host that samples late still sees the byte it asked for
  always_ff @(posedge core_clk) begin
    if (!rst_n) rdata <= 8'h00;
    else if (rd_en) rdata <= next_rdata;
  end

  // ==========================================================
  // field decode toward the analog and clocking logic; reserved bits
  // of each register are not looked at here
  wire logic [1:0] swing_code  = output_swing_mode[CCR_LSB_SWING +: 2];
  wire logic [1:0] single_code = input_select[CCR_LSB_SINGLE_IN +: 2];
  wire logic       dual_swap   = input_select[CCR_BIT_DUAL_SWAP];
  wire logic       cal_bit     = calibration_enable[CCR_BIT_CAL_EN];

  // swing selection; the reserved code gets its own mode value so that
  // a host writing it can be caught instead of silently remapped
  always_comb begin
    unique case (swing_code)
      CCR_SWING_HIGH:   output_drive_mode = CCR_DRV_HIGH_SWING;
      CCR_SWING_LOW:    output_drive_mode = CCR_DRV_LOW_SWING;
      CCR_SWING_RSVD:   output_drive_mode = CCR_DRV_RESERVED;
      CCR_SWING_HIGH_Z: output_drive_mode = CCR_DRV_HIGH_Z_SWING;
    endcase
  end

  // fullscale codes and receiver controls straight from the registers
  assign input_a_fullscale_code    = input_a_fullscale;
  assign input_b_fullscale_code    = input_b_fullscale;
  assign reference_bypass_bit      = reference_bypass[CCR_BIT_REF_BYP];
  assign timestamp_receiver_on     = timestamp_input_control[CCR_BIT_TS_RECV];
  assign timestamp_dc_coupled_mode = timestamp_input_control[CCR_BIT_TS_DC];

  // input routing: swap only in dual mode, selection only in interleave mode;
  // reserved single-input codes 0 and 3 select neither input
  assign channel_a_takes_second = !interleave_mode && dual_swap;
  assign channel_b_takes_first  = !interleave_mode && dual_swap;
  assign interleave_first_input_mode  =
    interleave_mode && (single_code == CCR_SINGLE_FIRST);
  assign interleave_second_input_mode =
    interleave_mode && (single_code == CCR_SINGLE_SECOND);

  // calibration run/hold and divider reset from one bit; the dividers
  // restart whenever calibration is held, and the host alone keeps the
  // order of this bit against the output interface enable
  assign calibration_run   = cal_bit;
  assign calibration_reset = !cal_bit;
  assign divider_reset     = !cal_bit;

endmodule : ccr_regs

// file: test/ccr_chk.sv
// Purpose: port assertions for the converter configuration registers
// Assumes: a byte write shows on the outputs one edge after it is taken
// Notes:   bound to every ccr_regs instance
`timescale 1ns/1ps
module ccr_chk
  import ccr_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic [11:0]            addr,
  input  wire logic [7:0]             wdata,
  input  wire logic [7:0]             rdata,
  input  wire logic                   interleave_mode,
  input  wire logic [15:0]            input_a_fullscale_code,
  input  wire logic [15:0]            input_b_fullscale_code,
  input  wire logic                   reference_bypass_bit,
  input  wire logic                   timestamp_receiver_on,
  input  wire logic                   timestamp_dc_coupled_mode,
  input  wire ccr_pkg::ccr_drv_mode_t output_drive_mode,
  input  wire logic                   channel_a_takes_second,
  input  wire logic                   channel_b_takes_first,
  input  wire logic                   interleave_first_input_mode,
  input  wire logic                   interleave_second_input_mode,
  input  wire logic                   calibration_run,
  input  wire logic                   calibration_reset,
  input  wire logic                   divider_reset
);
  // ==========================================================
  // write step and register checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(logic [11:0] a); wr_en && addr == a; endsequence
  property p_fs_a; s_wr(CCR_ADDR_FS_A_LO) |=> input_a_fullscale_code[7:0] == $past(wdata);
  endproperty
  a_fs_a: assert property (p_fs_a) else $error("first full-scale low byte");
  property p_fs_b; s_wr(CCR_ADDR_FS_B_HI) |=> input_b_fullscale_code[15:8] == $past(wdata);
  endproperty
  a_fs_b: assert property (p_fs_b) else $error("second full-scale high byte");
  property p_byp; s_wr(CCR_ADDR_REF_BYP) |=> reference_bypass_bit == $past(wdata[0]);
  endproperty
  a_byp: assert property (p_byp) else $error("reference bypass bit");
  property p_ts; s_wr(CCR_ADDR_TSTAMP) |=>
    {timestamp_dc_coupled_mode, timestamp_receiver_on} == $past(wdata[1:0]); endproperty
  a_ts: assert property (p_ts) else $error("timestamp control bits");
  property p_swing; s_wr(CCR_ADDR_SWING) ##0 wdata[1:0] == 2'h3 |=>
    output_drive_mode == CCR_DRV_HIGH_Z_SWING; endproperty
  a_swing: assert property (p_swing) else $error("swing code 3 decode");
  property p_dual; interleave_mode |-> !(channel_a_takes_second || channel_b_takes_first);
  endproperty
  a_dual: assert property (p_dual) else $error("swap active while interleaved");
  property p_single; !interleave_mode |->
    !(interleave_first_input_mode || interleave_second_input_mode); endproperty
  a_single: assert property (p_single) else $error("single input in dual mode");
  property p_cal; s_wr(CCR_ADDR_CAL_EN) |=> calibration_run == $past(wdata[0]) &&
    divider_reset == !calibration_run && calibration_reset == divider_reset; endproperty
  a_cal: assert property (p_cal) else $error("calibration enable outputs");
  property p_rd; rd_en && addr == CCR_ADDR_CAL_EN |=> rdata[0] == $past(calibration_run);
  endproperty
  a_rd: assert property (p_rd) else $error("calibration enable readback");
endmodule : ccr_chk
bind ccr_regs ccr_chk chk_u (
  .core_clk                     (core_clk),
  .rst_n                        (rst_n),
  .wr_en                        (wr_en),
  .rd_en                        (rd_en),
  .addr                         (addr),
  .wdata                        (wdata),
  .rdata                        (rdata),
  .interleave_mode              (interleave_mode),
  .input_a_fullscale_code       (input_a_fullscale_code),
  .input_b_fullscale_code       (input_b_fullscale_code),
  .reference_bypass_bit         (reference_bypass_bit),
  .timestamp_receiver_on        (timestamp_receiver_on),
  .timestamp_dc_coupled_mode    (timestamp_dc_coupled_mode),
  .output_drive_mode            (output_drive_mode),
  .channel_a_takes_second       (channel_a_takes_second),
  .channel_b_takes_first        (channel_b_takes_first),
  .interleave_first_input_mode  (interleave_first_input_mode),
  .interleave_second_input_mode (interleave_second_input_mode),
  .calibration_run              (calibration_run),
  .calibration_reset            (calibration_reset),
  .divider_reset                (divider_reset)
);

// file: test/ccr_host.sv
// Purpose: host model driving the byte register port
// Assumes: one strobe per access, rdata valid after the taking edge
// Notes:   wdata is inverted once a write is done
`timescale 1ns/1ps
module ccr_host (
  input  wire logic        core_clk,
  output logic             wr_en,
  output logic             rd_en,
  output logic [11:0]      addr,
  output logic [7:0]       wdata,
  input  wire logic [7:0]  rdata
);
  // idle port at time zero
  initial begin
    {wr_en, rd_en, addr, wdata} = '0;
  end
  // ==========================================================
  // bus cycles
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    {wr_en, addr, wdata} <= {1'h1, a, v};
    @(posedge core_clk);
    {wr_en, wdata} <= {1'h0, ~v};
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge core_clk);
    {rd_en, addr} <= {1'h1, a};
    @(posedge core_clk);
    rd_en <= 1'h0;
    @(negedge core_clk);
    v = rdata;
  endtask : rd
endmodule : ccr_host

// file: test/tb_top.sv
// Purpose: register tests for the converter configuration registers
// Assumes: host model does the bus cycles
// Notes:   expectations come from the register table
`timescale 1ns/1ps
module tb_top;
  import ccr_pkg::*;
  logic core_clk, rst_n, interleave_mode, wr_en, rd_en;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [15:0] fs_a, fs_b;
  logic byp, ts_on, ts_dc, ca2, cb1, m1, m2, crun, crst, drst;
  ccr_drv_mode_t drv;
  int miscompares, comparisons;
  logic [11:0] ra[9] = '{12'h030, 12'h031, 12'h032, 12'h033, 12'h038, 12'h03B, 12'h048,
                         12'h060, 12'h061};
  logic [7:0] rv[9] = '{8'h00, 8'hA0, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [7:0] wv[9] = '{8'h00, 8'h20, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFC, 8'hEE, 8'hFE};
  logic [3:0] sw[4] = '{4'h1, 4'h2, 4'h8, 4'h4};
  ccr_host host_u (.core_clk(core_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata));
  ccr_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .interleave_mode(interleave_mode),
    .input_a_fullscale_code(fs_a), .input_b_fullscale_code(fs_b), .reference_bypass_bit(byp),
    .timestamp_receiver_on(ts_on), .timestamp_dc_coupled_mode(ts_dc), .output_drive_mode(drv),
    .channel_a_takes_second(ca2), .channel_b_takes_first(cb1), .calibration_run(crun),
    .interleave_first_input_mode(m1), .interleave_second_input_mode(m2),
    .calibration_reset(crst), .divider_reset(drst));
  // ==========================================================
  // compare, read and finish
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rc
  task automatic close_out();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // clock and watchdog
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
  // ==========================================================
  // test sequence
  initial begin
    {rst_n, interleave_mode, miscompares, comparisons} = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 9; i++) rc(ra[i], rv[i]);
    host_u.wr(CCR_ADDR_CAL_EN, 8'h00);
    for (int i = 0; i < 9; i++) host_u.wr(ra[i], wv[i]);
    chk(fs_a, 16'h2000);
    chk(fs_b, 16'hFFFF);
    chk({13'h0, byp, ts_dc, ts_on}, 16'h0006);
    chk({13'h0, crun, crst, drst}, 16'h0003);
    for (int i = 0; i < 9; i++) rc(ra[i], wv[i]);
    host_u.wr(12'h034, 8'h5A);
    rc(12'h034, 8'h00);
    host_u.wr(CCR_ADDR_CAL_EN, 8'h01);
    chk({13'h0, crun, crst, drst}, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(CCR_ADDR_SWING, 8'hF0 | 8'(i));
      chk({12'h0, drv}, {12'h0, sw[i]});
    end
    host_u.wr(CCR_ADDR_SWING, 8'h00);
    chk({12'h0, drv}, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      if (i % 2 == 0) host_u.wr(CCR_ADDR_IN_SEL, 8'hEC | {3'h0, i[3], 2'h0, i[2:1]});
      @(posedge core_clk);
      interleave_mode <= i[0];
      @(negedge core_clk);
      chk({12'h0, ca2, cb1, m1, m2}, {12'h0, {2{!i[0] && i[3]}}, i[0] && i[2:1] == 2'h1,
        i[0] && i[2:1] == 2'h2});
    end
    @(posedge core_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    rc(CCR_ADDR_IN_SEL, 8'h01);
    chk(fs_a, 16'hA000);
    close_out();
  end
endmodule : tb_top
